// >>> rtl/module_bus_host.sv
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// processor-side bus master, ordered over apb
// ----------------------------------------------------------------------
module module_bus_host
    import adc_bus_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    module_bus_if.host bus
);

    typedef enum logic {ST_IDLE, ST_ACCESS} host_state_t;

    host_state_t state_ff;          // bus master state
    host_state_t nxt_state;
    logic [1:0] slot_ff;            // clock within the access
    logic wr_ff;                    // latched direction
    logic privilege_restrict_bit_ff;                  // latched privilege
    logic [ADDR_W-1:0] addr_ff;     // target offset
    logic [DATA_W-1:0] wdata_ff;    // data to write
    logic [DATA_W-1:0] rdata_ff;    // data last read
    logic done_ff;                  // sticky: access finished
    logic unclaimed_ff;             // sticky: access went unanswered
    logic halt_ff;                  // debug halt level

    // ------------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------------
    wire logic apb_wr;   // write access phase
    wire logic hit_cmd;
    wire logic hit_addr;
    wire logic hit_wdata;
    wire logic hit_rdata;
    wire logic hit_status;
    wire logic hit_halt;
    wire logic mapped;
    wire logic go;       // start request
    wire logic finish;   // last clock of an access
    wire logic clr_done; // software clear of done
    wire logic clr_uncl; // software clear of unclaimed

    assign apb_wr = psel && penable && pwrite;
    assign hit_cmd = (paddr == APB_CMD);
    assign hit_addr = (paddr == APB_ADDR);
    assign hit_wdata = (paddr == APB_WDATA);
    assign hit_rdata = (paddr == APB_RDATA);
    assign hit_status = (paddr == APB_STATUS);
    assign hit_halt = (paddr == APB_HALT);
    assign mapped = hit_cmd || hit_addr || hit_wdata || hit_rdata || hit_status || hit_halt;

    // zero-wait slave; unmapped offsets answer with an error
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;

    // a go while busy is dropped, software must poll busy first
    assign go = apb_wr && hit_cmd && pwdata[CMD_GO_BIT] && (state_ff == ST_IDLE);
    assign finish = (state_ff == ST_ACCESS) && (slot_ff == BUS_LAST);
    assign clr_done = apb_wr && hit_status && pwdata[ST_DONE_BIT];
    assign clr_uncl = apb_wr && hit_status && pwdata[ST_UNCLAIMED_BIT];

    // read mux
    always_comb begin
        prdata = 32'h00000000;
        if (hit_addr) begin
            prdata = {26'h0000000, addr_ff};
        end else if (hit_wdata) begin
            prdata = {16'h0000, wdata_ff};
        end else if (hit_rdata) begin
            prdata = {16'h0000, rdata_ff};
        end else if (hit_status) begin
            prdata = {29'h00000000, unclaimed_ff, done_ff, state_ff == ST_ACCESS};
        end else if (hit_halt) begin
            prdata = {31'h00000000, halt_ff};
        end
    end

    // ------------------------------------------------------------------
    // request registers
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            addr_ff <= 6'h00;
            wdata_ff <= 16'h0000;
            halt_ff <= 1'b0;
        end else if (apb_wr && hit_addr) begin
            addr_ff <= pwdata[ADDR_W-1:0];
        end else if (apb_wr && hit_wdata) begin
            wdata_ff <= pwdata[DATA_W-1:0];
        end else if (apb_wr && hit_halt) begin
            halt_ff <= pwdata[0];
        end
    end

    // direction and privilege are taken with the go
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            wr_ff <= 1'b0;
            privilege_restrict_bit_ff <= 1'b0;
        end else if (go) begin
            wr_ff <= pwdata[CMD_WR_BIT];
            privilege_restrict_bit_ff <= pwdata[CMD_PRIVILEGE_RESTRICT_BIT_BIT];
        end
    end

    // ------------------------------------------------------------------
    // three-clock bus cycle
    // ------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            ST_IDLE: begin
                if (go) begin
                    nxt_state = ST_ACCESS;
                end
            end
            ST_ACCESS: begin
                if (finish) begin
                    nxt_state = ST_IDLE;
                end
            end
            default: begin
                nxt_state = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_ff <= ST_IDLE;
            slot_ff <= 2'h0;
        end else begin
            state_ff <= nxt_state;
            slot_ff <= (state_ff == ST_ACCESS && !finish) ? slot_ff + 2'h1 : 2'h0;
        end
    end

    // read data captured at termination
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            rdata_ff <= 16'h0000;
        end else if (finish && bus.ack && !wr_ff) begin
            rdata_ff <= bus.rdata;
        end
    end

    // sticky flags: a new event wins over a clear in the same clock
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            done_ff <= 1'b0;
            unclaimed_ff <= 1'b0;
        end else begin
            done_ff <= finish || (done_ff && !clr_done);
            unclaimed_ff <= (finish && !bus.ack) || (unclaimed_ff && !clr_uncl);
        end
    end

    assign bus.cyc = (state_ff == ST_ACCESS);
    assign bus.wr = wr_ff;
    assign bus.addr = addr_ff;
    assign bus.wdata = wdata_ff;
    assign bus.privilege_restrict_bit = privilege_restrict_bit_ff;
    assign bus.debug_halt = halt_ff;

endmodule : module_bus_host

// >>> rtl/adc_bus_pkg.sv
// ----------------------------------------------------------------------
// shared constants for the converter configuration block
// ----------------------------------------------------------------------
package adc_bus_pkg;

    // ------------------------------------------------------------------
    // module bus geometry
    // ------------------------------------------------------------------
    localparam int ADDR_W = 6;  // byte offset within the module window
    localparam int DATA_W = 16; // module bus data width
    localparam int PORT_W = 8;  // width of each digital port

    // ------------------------------------------------------------------
    // device register offsets
    // ------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] OFS_MODULE_CONFIG = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_FACTORY_TEST = 6'h02;
    localparam logic [ADDR_W-1:0] OFS_PORT_DATA = 6'h06;

    // ------------------------------------------------------------------
    // module config field positions and reset values
    // ------------------------------------------------------------------
    localparam int MCR_STOP_BIT = 15;
    localparam int MCR_FRZ_HI = 14;
    localparam int MCR_FRZ_LO = 13;
    localparam int MCR_PRIVILEGE_RESTRICT_BIT_BIT = 7;
    localparam logic MCR_STOP_RST = 1'h1;
    localparam logic [1:0] MCR_FRZ_RST = 2'h0;
    localparam logic MCR_PRIVILEGE_RESTRICT_BIT_RST = 1'h0;
    localparam logic [DATA_W-1:0] TEST_RST = 16'h0000;
    localparam logic [PORT_W-1:0] PORT_OUT_RST = 8'h00;

    // freeze response codes
    localparam logic [1:0] FRZ_IGNORE = 2'h0;
    localparam logic [1:0] FRZ_RESERVED = 2'h1;
    localparam logic [1:0] FRZ_FINISH = 2'h2;
    localparam logic [1:0] FRZ_NOW = 2'h3;

    // ------------------------------------------------------------------
    // bus cycle timing: three clocks per access
    // ------------------------------------------------------------------
    localparam int BUS_CLOCKS = 3;
    localparam logic [1:0] BUS_LAST = 2'(BUS_CLOCKS - 1);

    // ------------------------------------------------------------------
    // controller apb register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_ADDR = 8'h04;
    localparam logic [7:0] APB_WDATA = 8'h08;
    localparam logic [7:0] APB_RDATA = 8'h0C;
    localparam logic [7:0] APB_STATUS = 8'h10;
    localparam logic [7:0] APB_HALT = 8'h14;
    localparam int CMD_GO_BIT = 0;
    localparam int CMD_WR_BIT = 1;
    localparam int CMD_PRIVILEGE_RESTRICT_BIT_BIT = 2;
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_DONE_BIT = 1;
    localparam int ST_UNCLAIMED_BIT = 2;

endpackage : adc_bus_pkg

// >>> rtl/module_bus_if.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// on-chip module bus between processor side and converter block
// ----------------------------------------------------------------------
interface module_bus_if;
    import adc_bus_pkg::*;

    logic cyc;                 // bus cycle in progress, held three clocks
    logic wr;                  // 1 = write, 0 = read
    logic [ADDR_W-1:0] addr;   // byte offset
    logic [DATA_W-1:0] wdata;  // write data
    logic privilege_restrict_bit;                // 1 = supervisor privilege
    logic debug_halt;          // processor debug halt level
    logic [DATA_W-1:0] rdata;  // read data, valid with ack
    logic ack;                 // cycle termination by the device

    // converter end
    modport device (
        input cyc, wr, addr, wdata, privilege_restrict_bit, debug_halt,
        output rdata, ack
    );

    // processor end
    modport host (
        output cyc, wr, addr, wdata, privilege_restrict_bit, debug_halt,
        input rdata, ack
    );

endinterface : module_bus_if

// >>> rtl/adc_config_port.sv
`timescale 1ns/1ps
// Overview of operation
// [RULE_01] input pins appear in port data low byte
// [RULE_02] input synchronizers run only during port access
// [RULE_03] output latches in high byte drive pins
// [RULE_04] high byte read returns output latch
// [RULE_05] writes take effect at once
// [RULE_06] control write aborts running conversion
// [RULE_07] each access takes three clocks
// [RULE_08] result transfers avoid bus access slots
// [RULE_09] stop gates core clock, bus stays alive
// [RULE_10] setting stop aborts running conversion
// [RULE_11] reset sets stop, software clears it
// [RULE_12] software waits for bias recovery
// [RULE_13] global stop leaves stop bit alone
// [RULE_14] software sets stop before global stop
// [RULE_15] freeze field selects debug halt response
// [RULE_16] frozen: core idle, registers valid, resume
// [RULE_17] frozen conversion continues after release
// [RULE_18] config and test registers supervisor only
// [RULE_19] restrict bit makes all supervisor only
// [RULE_20] refused access gets no termination
// [RULE_21] no privilege levels means supervisor
// [RULE_22] port read never disturbs conversion
// [RULE_23] high byte reads back last write
// [RULE_24] reserved freeze code acts as ignore
module adc_config_port
    import adc_bus_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    module_bus_if.device bus,
    input wire logic priv_levels_en,
    input wire logic [PORT_W-1:0] digital_input_pins,
    output logic [PORT_W-1:0] digital_output_pins,
    input wire logic conv_busy,
    input wire logic xfer_req,
    output logic xfer_grant,
    output logic conv_abort,
    output logic core_clk_en,
    output logic freeze_hold,
    output logic stop_mode
);

    // ------------------------------------------------------------------
    // configuration and port state
    // ------------------------------------------------------------------
    logic stop_ff;                     // low-power stop bit
    logic [1:0] frz_ff;                // freeze response field
    logic privilege_restrict_bit_ff;                     // privilege restrict bit
    logic [DATA_W-1:0] test_ff;        // factory test register contents
    logic [PORT_W-1:0] port_out_ff;    // output port latch
    logic [PORT_W-1:0] in_meta_ff;     // first synchronizer stage
    logic [PORT_W-1:0] in_sync_ff;     // second synchronizer stage
    logic [1:0] slot_ff;               // clock index within a bus cycle
    logic frozen_ff;                   // core held by debug halt
    logic abort_ff;                    // one-cycle abort pulse

    // next values
    logic [1:0] nxt_slot;
    logic nxt_frozen;
    logic nxt_abort;

    // ------------------------------------------------------------------
    // address decode and privilege check
    // ------------------------------------------------------------------
    wire logic hit_config; // module config selected
    wire logic hit_test;   // factory test selected
    wire logic hit_port;   // port data selected
    wire logic eff_privilege_restrict_bit;   // privilege as seen by the block
    wire logic need_privilege_restrict_bit;  // selected register wants supervisor
    wire logic claimed;    // this block answers the cycle
    wire logic last_slot;  // final clock of the three
    wire logic do_write;   // write completes this edge
    wire logic [DATA_W-1:0] read_mux;

    assign hit_config = bus.cyc && (bus.addr == OFS_MODULE_CONFIG);
    assign hit_test = bus.cyc && (bus.addr == OFS_FACTORY_TEST);
    assign hit_port = bus.cyc && (bus.addr == OFS_PORT_DATA);

    // [RULE_21] no privilege levels
    assign eff_privilege_restrict_bit = bus.privilege_restrict_bit || !priv_levels_en;

    // [RULE_18] config/test supervisor only
    // [RULE_19] restrict bit widens it
    assign need_privilege_restrict_bit = hit_config || hit_test || (hit_port && privilege_restrict_bit_ff);

    // [RULE_20] refused cycles unclaimed
    assign claimed = (hit_config || hit_test || hit_port) && (eff_privilege_restrict_bit || !need_privilege_restrict_bit);

    assign last_slot = (slot_ff == BUS_LAST);
    assign do_write = claimed && bus.wr && last_slot;

    // ------------------------------------------------------------------
    // bus cycle timing
    // ------------------------------------------------------------------
    // slot counter follows the host's three-clock cycle; it restarts
    // whenever the cycle line drops, so a short cycle cannot desync it
    assign nxt_slot = (bus.cyc && !last_slot) ? slot_ff + 2'h1 : 2'h0;

    // [RULE_07] terminate on third clock
    assign bus.ack = claimed && last_slot;

    // read data only shows while terminating; zero otherwise
    assign bus.rdata = bus.ack ? read_mux : 16'h0000;

    // read selection from flops only
    // [RULE_01] pins in low byte
    // [RULE_04] latch in high byte
    // [RULE_23] last written value
    assign read_mux = hit_config ?
        {stop_ff, frz_ff, 5'h00, privilege_restrict_bit_ff, 7'h00} :
        hit_test ? test_ff : {port_out_ff, in_sync_ff};

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            slot_ff <= 2'h0;
        end else begin
            slot_ff <= nxt_slot;
        end
    end

    // ------------------------------------------------------------------
    // gated input synchronizer
    // ------------------------------------------------------------------
    // pins are only sampled while the port is addressed, which keeps
    // mid-level analog signals from toggling the digital input stages.
    // the pins are stable for two clocks before the third-clock read.
    // [RULE_02] synchronizer enable
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            in_meta_ff <= 8'h00;
            in_sync_ff <= 8'h00;
        end else if (hit_port) begin
            in_meta_ff <= digital_input_pins;
            in_sync_ff <= in_meta_ff;
        end
    end

    // ------------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------------
    // every write lands on the terminating edge, no shadow copy
    // [RULE_05] immediate update
    // [RULE_11] reset sets stop
    // [RULE_13] only reset or a write moves stop
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            stop_ff <= MCR_STOP_RST;
            frz_ff <= MCR_FRZ_RST;
            privilege_restrict_bit_ff <= MCR_PRIVILEGE_RESTRICT_BIT_RST;
        end else if (do_write && hit_config) begin
            stop_ff <= bus.wdata[MCR_STOP_BIT];
            frz_ff <= bus.wdata[MCR_FRZ_HI:MCR_FRZ_LO];
            privilege_restrict_bit_ff <= bus.wdata[MCR_PRIVILEGE_RESTRICT_BIT_BIT];
        end
    end

    // factory test word is only stored here
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            test_ff <= TEST_RST;
        end else if (do_write && hit_test) begin
            test_ff <= bus.wdata;
        end
    end

    // low byte of the port register is read only
    // [RULE_03] output latch write
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            port_out_ff <= PORT_OUT_RST;
        end else if (do_write && hit_port) begin
            port_out_ff <= bus.wdata[DATA_W-1:PORT_W];
        end
    end

    // [RULE_03] drive output pins
    assign digital_output_pins = port_out_ff;

    // ------------------------------------------------------------------
    // conversion abort
    // ------------------------------------------------------------------
    // any config write during a conversion stops it; this also covers
    // stop being set. port data writes and reads leave it running.
    // [RULE_06] control write halts
    // [RULE_10] stop aborts
    // [RULE_22] port access never aborts
    assign nxt_abort = do_write && hit_config && conv_busy;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            abort_ff <= 1'b0;
        end else begin
            abort_ff <= nxt_abort;
        end
    end

    assign conv_abort = abort_ff;

    // ------------------------------------------------------------------
    // freeze on debug halt
    // ------------------------------------------------------------------
    // the core keeps its step state while held, so release continues
    // the sequence; held charge may droop, which software must accept
    // [RULE_15] freeze field response
    // [RULE_24] reserved code ignores
    // [RULE_16] release on negation
    always_comb begin
        nxt_frozen = frozen_ff;
        if (!bus.debug_halt) begin
            nxt_frozen = 1'b0;
        end else if (frz_ff == FRZ_NOW) begin
            nxt_frozen = 1'b1;
        end else if (frz_ff == FRZ_FINISH) begin
            nxt_frozen = frozen_ff || !conv_busy;
        end else begin
            nxt_frozen = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            frozen_ff <= 1'b0;
        end else begin
            frozen_ff <= nxt_frozen;
        end
    end

    // [RULE_17] hold, not restart
    assign freeze_hold = frozen_ff;

    // ------------------------------------------------------------------
    // core clock gating and transfer slots
    // ------------------------------------------------------------------
    // [RULE_09] stop gates core only
    // [RULE_16] freeze stops core
    assign core_clk_en = !stop_ff && !frozen_ff;
    assign stop_mode = stop_ff;

    // result transfers only in clocks with no bus cycle running
    // [RULE_08] non-overlapping slots
    assign xfer_grant = xfer_req && !bus.cyc && core_clk_en;

endmodule : adc_config_port

// >>> dv/adc_bus_sva.sv
`timescale 1ns/1ps
module adc_bus_sva
    import adc_bus_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic priv_levels_en,
    input wire logic cyc,
    input wire logic privilege_restrict_bit,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] rdata,
    input wire logic ack,
    input wire logic xfer_grant
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // ----
    // decode helpers
    // ----
    wire known_ofs = (addr == OFS_MODULE_CONFIG) || (addr == OFS_FACTORY_TEST)
        || (addr == OFS_PORT_DATA);
    wire super_only = (addr == OFS_MODULE_CONFIG) || (addr == OFS_FACTORY_TEST);
    sequence cyc_start;
        $rose(cyc);
    endsequence
    sequence user_start;
        cyc_start ##0 (priv_levels_en && !privilege_restrict_bit);
    endsequence
    // ----
    // properties
    // ----
    a_cyc_three_clk: assert property (cyc_start |-> cyc[*3] ##1 !cyc)
        else $error("bus cycle not three clocks");
    a_ack_slot_two: assert property (ack |-> cyc && $past(cyc) && $past(cyc, 2))
        else $error("ack outside third clock");
    a_ack_one_clk: assert property (ack |=> !ack)
        else $error("ack longer than one clock");
    a_rdata_quiet: assert property (!ack |-> rdata == '0)
        else $error("read data without ack");
    a_user_sv_refused: assert property (user_start ##0 super_only |-> !ack[*3])
        else $error("user access to supervisor register claimed");
    a_unmapped_quiet: assert property (cyc && !known_ofs |-> !ack)
        else $error("unmapped offset claimed");
    a_privilege_restrict_bit_claimed: assert property (cyc_start ##0 (privilege_restrict_bit && known_ofs) |-> ##2 ack)
        else $error("supervisor access not claimed");
    a_nopriv_claimed: assert property (cyc_start ##0 (!priv_levels_en && known_ofs)
        |-> ##2 ack)
        else $error("access without privilege levels not claimed");
    a_xfer_no_cyc: assert property (cyc |-> !xfer_grant)
        else $error("result transfer granted during bus cycle");
endmodule : adc_bus_sva

// >>> dv/tb.sv
`timescale 1ns/1ps
module tb
    import adc_bus_pkg::*;
;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd, dv;
    logic pready, pslverr, err;
    logic priv_levels_en = 1'b1;
    logic [7:0] pins = 8'h00;
    logic [7:0] outs;
    logic conv_busy = 1'b0;
    logic xfer_req = 1'b1;
    logic xfer_grant, conv_abort, core_clk_en, freeze_hold, stop_mode;
    logic abort_seen = 1'b0; // sticky catch of the one-clock abort pulse
    logic [2:0] stat;
    int num_errors = 0;
    int tests_run = 0;
    always #50 clock = ~clock;
    always @(posedge clock) if (conv_abort === 1'b1) abort_seen <= 1'b1;
    // ----
    // both ends joined by the bus
    // ----
    module_bus_if bus_if ();
    adc_config_port u_adc_config_port (.clock(clock), .rstn(rstn), .bus(bus_if),
        .priv_levels_en(priv_levels_en), .digital_input_pins(pins),
        .digital_output_pins(outs), .conv_busy(conv_busy), .xfer_req(xfer_req),
        .xfer_grant(xfer_grant), .conv_abort(conv_abort), .core_clk_en(core_clk_en),
        .freeze_hold(freeze_hold), .stop_mode(stop_mode));
    module_bus_host u_module_bus_host (.clock(clock), .rstn(rstn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(bus_if));
    adc_bus_sva u_adc_bus_sva (.clock(clock), .rstn(rstn), .priv_levels_en(priv_levels_en),
        .cyc(bus_if.cyc), .privilege_restrict_bit(bus_if.privilege_restrict_bit), .addr(bus_if.addr), .rdata(bus_if.rdata),
        .ack(bus_if.ack), .xfer_grant(xfer_grant));
    // ----
    // tasks
    // ----
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    // one apb transfer; read data lands in rd at the ready edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) begin
            num_errors++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // one module bus access through the host; status lands in stat, data in dv
    task automatic dev(input logic w, input logic s, input logic [5:0] a,
        input logic [15:0] d);
        int n;
        apb(1'b1, APB_ADDR, {26'h0, a});
        apb(1'b1, APB_WDATA, {16'h0, d});
        apb(1'b1, APB_CMD, {29'h0, s, w, 1'b1});
        n = 0;
        do begin
            apb(1'b0, APB_STATUS, 32'h0);
            n++;
        end while (rd[ST_DONE_BIT] !== 1'b1 && rd[ST_UNCLAIMED_BIT] !== 1'b1 && n < 20);
        if (rd[ST_DONE_BIT] !== 1'b1 && rd[ST_UNCLAIMED_BIT] !== 1'b1) begin
            num_errors++;
            final_report();
        end
        stat = rd[2:0];
        apb(1'b0, APB_RDATA, 32'h0);
        dv = rd;
        apb(1'b1, APB_STATUS, 32'h6);
    endtask : dev
    // privilege probe: a read that must be claimed or left unclaimed
    task automatic acc(input logic pe, input logic s, input logic [5:0] a, input logic u);
        priv_levels_en <= pe;
        dev(1'b0, s, a, 16'h0);
        check(stat[ST_UNCLAIMED_BIT], u);
    endtask : acc
    task automatic settle();
        repeat (3) @(negedge clock);
        @(posedge clock);
    endtask : settle
    // ----
    // main sequence
    // ----
    initial begin
        repeat (5) @(posedge clock);
        rstn <= 1'b1;
        check(stop_mode, 1);
        check(outs, PORT_OUT_RST);
        dev(1'b0, 1'b1, OFS_MODULE_CONFIG, 16'h0);
        check(dv & 32'hE080, 32'h8000);
        dev(1'b1, 1'b1, OFS_MODULE_CONFIG, 16'h0);
        check({stop_mode, core_clk_en, xfer_grant}, 3'b011);
        settle();
        pins <= 8'hA5;
        dev(1'b1, 1'b1, OFS_PORT_DATA, 16'h3C00);
        check(outs, 8'h3C);
        dev(1'b0, 1'b1, OFS_PORT_DATA, 16'h0);
        check(dv, 32'h3CA5);
        check(stat, 3'b010);
        acc(1'b1, 1'b0, OFS_MODULE_CONFIG, 1'b1);
        acc(1'b1, 1'b0, OFS_FACTORY_TEST, 1'b1);
        acc(1'b1, 1'b0, OFS_PORT_DATA, 1'b0);
        acc(1'b1, 1'b1, 6'h04, 1'b1);
        acc(1'b0, 1'b0, OFS_MODULE_CONFIG, 1'b0);
        acc(1'b1, 1'b1, OFS_MODULE_CONFIG, 1'b0);
        dev(1'b1, 1'b1, OFS_MODULE_CONFIG, 16'h0080);
        acc(1'b1, 1'b0, OFS_PORT_DATA, 1'b1);
        acc(1'b1, 1'b1, OFS_PORT_DATA, 1'b0);
        // every freeze code, idle converter
        for (int c = 0; c < 4; c++) begin
            dev(1'b1, 1'b1, OFS_MODULE_CONFIG, {1'b0, 2'(c), 13'h0});
            apb(1'b1, APB_HALT, 32'h1);
            settle();
            check({freeze_hold, core_clk_en}, (c >= 2) ? 2'b10 : 2'b01);
            apb(1'b1, APB_HALT, 32'h0);
            settle();
            check({freeze_hold, core_clk_en}, 2'b01);
        end
        // finish-then-freeze with a conversion running; the write itself aborts it
        conv_busy <= 1'b1;
        abort_seen <= 1'b0;
        dev(1'b1, 1'b1, OFS_MODULE_CONFIG, 16'h4000);
        check(abort_seen, 1);
        apb(1'b1, APB_HALT, 32'h1);
        settle();
        check(freeze_hold, 0);
        conv_busy <= 1'b0;
        settle();
        check(freeze_hold, 1);
        apb(1'b1, APB_HALT, 32'h0);
        conv_busy <= 1'b1;
        abort_seen <= 1'b0;
        dev(1'b0, 1'b1, OFS_PORT_DATA, 16'h0);
        check(abort_seen, 0);
        dev(1'b1, 1'b1, OFS_MODULE_CONFIG, 16'h8000);
        check(abort_seen, 1);
        check({stop_mode, core_clk_en, xfer_grant}, 3'b100);
        dev(1'b1, 1'b1, OFS_FACTORY_TEST, 16'h5AA5);
        dev(1'b0, 1'b1, OFS_FACTORY_TEST, 16'h0);
        check(dv, 32'h5AA5);
        apb(1'b0, 8'h18, 32'h0);
        check(err, 1);
        final_report();
    end
endmodule : tb
